/* verilog/gdp_pkg.sv */
package gdp_pkg;

    // ----------------------------------------
    // Register offsets (configuration space bytes)
    // ----------------------------------------
    localparam logic [7:0] GDP_OFS_PIN_DIRECTION = 8'hb4;
    localparam logic [7:0] GDP_OFS_PIN_LEVEL = 8'hb6;
    localparam logic [7:0] GDP_OFS_CTRL_DIAG0 = 8'hc0;

    // ----------------------------------------
    // Field layout and reset values
    // ----------------------------------------
    localparam int GDP_PINS = 8;
    localparam int GDP_SCL_PIN = 4;
    localparam int GDP_SDA_PIN = 5;
    localparam logic [7:0] GDP_DIR_RESET = 8'h00;
    localparam logic [7:0] GDP_LEVEL_RESET = 8'h00;
    localparam logic [7:0] GDP_RSVD_BYTE = 8'h00;
    localparam logic [31:0] GDP_CTRL_DIAG0_RESET = 32'h0000_0000;

    // ----------------------------------------
    // Register access carrier
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } gdp_req_s;

    // Per-pin secondary function drive (enable and level) for pins 4 and 5
    typedef struct packed {
        logic scl_oe;
        logic scl_out;
        logic sda_oe;
        logic sda_out;
    } gdp_serial_s;

endpackage

/* verilog/gdp_port.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Direction bits 7..0 pick input (0) or output (1); reset to input.
// - Pins 4 and 5 ignore direction while serial bus owns them.
// - Direction upper byte is reserved and always reads zero.
// - Input pins read back their live level in the data register.
// - Writing a data bit of an output pin changes the driven level.
// - Data writes to input or serial-owned pins are discarded.
// - After reset data upper byte reads zero, low byte shows pins.
// - Link reset, global reset or power-on reset restore the defaults.
// - 32-bit control/diagnostic register, read/write, resets to zero.
// - Serial enable hands pins 4 and 5 to serial clock and data.
module gdp_port
    import gdp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic link_reset_n,
    input wire logic global_reset_n,
    input wire gdp_req_s req,
    output logic [31:0] rdata,
    input wire logic serial_bus_enable,
    input wire gdp_serial_s serial,
    output logic serial_scl_in,
    output logic serial_sda_in,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe
);

    // ----------------------------------------
    // Reset combining
    // ----------------------------------------
    // three reset sources
    // One combined net keeps every flop on a single async reset
    logic rst_n;
    assign rst_n = resetn & link_reset_n & global_reset_n;

    // ----------------------------------------
    // Pin ownership
    // ----------------------------------------
    function automatic logic [7:0] serial_mask(input logic en);
        logic [7:0] m;
        m = 8'h00;
        m[GDP_SCL_PIN] = en;
        m[GDP_SDA_PIN] = en;
        return m;
    endfunction

    // Byte lane hit on a 16-bit register at a half-word offset
    function automatic logic lane_hit(input gdp_req_s r,
                                      input logic [7:0] ofs);
        return r.wr && r.addr == ofs && r.be[0];
    endfunction

    // Read strobe aimed at one register offset
    function automatic logic read_hit(input gdp_req_s r,
                                      input logic [7:0] ofs);
        return r.rd && r.addr == ofs;
    endfunction

    // Byte enables widened to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    logic [7:0] dir_q, dir_d;
    logic [7:0] level_q, level_d;
    logic [31:0] diag_q, diag_d;
    logic [7:0] sec_mask, gpio_out_en;

    // serial enable takes pins 4 and 5
    assign sec_mask = serial_bus_enable ? serial_mask(1'b1) : 8'h00;
    assign gpio_out_en = dir_q & ~sec_mask;

    // ----------------------------------------
    // Register next state
    // ----------------------------------------
    always_comb begin
        dir_d = dir_q;
        level_d = level_q;
        diag_d = diag_q;
        if (lane_hit(req, GDP_OFS_PIN_DIRECTION)) begin
            dir_d = req.wdata[7:0];
        end
        // input and serial pins keep old value
        if (lane_hit(req, GDP_OFS_PIN_LEVEL)) begin
            level_d = (req.wdata[7:0] & gpio_out_en) |
                      (level_q & ~gpio_out_en);
        end
        if (req.wr && req.addr == GDP_OFS_CTRL_DIAG0) begin
            // Mask keeps bytes whose lane is off
            diag_d = (req.wdata & lane_mask(req.be)) |
                     (diag_q & ~lane_mask(req.be));
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dir_q <= GDP_DIR_RESET;
            level_q <= GDP_LEVEL_RESET;
            diag_q <= GDP_CTRL_DIAG0_RESET;
        end else begin
            dir_q <= dir_d;
            level_q <= level_d;
            diag_q <= diag_d;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [31:0] rdata_d, rdata_q;
    logic [7:0] level_view;

    // input pins show the live level
    assign level_view = (level_q & gpio_out_en) | (pin_in & ~gpio_out_en);

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (read_hit(req, GDP_OFS_PIN_DIRECTION)) begin
            rdata_d = {16'h0000, GDP_RSVD_BYTE, dir_q};
        end else if (read_hit(req, GDP_OFS_PIN_LEVEL)) begin
            // upper byte zero, low byte pins
            rdata_d = {16'h0000, GDP_RSVD_BYTE, level_view};
        end else if (read_hit(req, GDP_OFS_CTRL_DIAG0)) begin
            rdata_d = diag_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign rdata = rdata_q;

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    logic [7:0] out_d, oe_d;

    always_comb begin
        // float unless output and not secondary
        out_d = level_q & gpio_out_en;
        oe_d = gpio_out_en;
        // serial engine drives its own pins
        if (serial_bus_enable) begin
            out_d[GDP_SCL_PIN] = serial.scl_out;
            oe_d[GDP_SCL_PIN] = serial.scl_oe;
            out_d[GDP_SDA_PIN] = serial.sda_out;
            oe_d[GDP_SDA_PIN] = serial.sda_oe;
        end
    end

    // Combinational so the serial engine keeps its own bit timing
    assign pin_out = out_d;
    assign pin_oe = oe_d;
    assign serial_scl_in = pin_in[GDP_SCL_PIN];
    assign serial_sda_in = pin_in[GDP_SDA_PIN];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    rsvd_dir_zero_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        req.rd && req.addr == GDP_OFS_PIN_DIRECTION |=>
            rdata[31:8] == 24'h000000 && rdata[7:0] == $past(dir_q))
        else $error("direction read wrong");

    dir_write_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        req.wr && req.addr == GDP_OFS_PIN_DIRECTION && req.be[0] |=>
            dir_q == $past(req.wdata[7:0]))
        else $error("direction write lost");

    level_out_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        req.wr && req.addr == GDP_OFS_PIN_LEVEL && req.be[0] |=>
            ((level_q ^ $past(req.wdata[7:0])) & $past(gpio_out_en))
            == 8'h00)
        else $error("output data not taken");

    level_ignore_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ##1 ((level_q ^ $past(level_q)) & ~$past(gpio_out_en)) == 8'h00)
        else $error("ignored data bit changed");

    input_read_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        req.rd && req.addr == GDP_OFS_PIN_LEVEL |=>
            ((rdata[7:0] ^ $past(pin_in)) & ~$past(gpio_out_en)) == 8'h00
            && rdata[15:8] == 8'h00)
        else $error("input level not read");

    serial_own_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        serial_bus_enable |-> pin_oe[GDP_SCL_PIN] == serial.scl_oe
            && pin_oe[GDP_SDA_PIN] == serial.sda_oe)
        else $error("serial pins not handed over");

    drive_gate_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (pin_oe & ~sec_mask) == (dir_q & ~sec_mask))
        else $error("driver enable mismatch");

    diag_rw_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        req.wr && req.addr == GDP_OFS_CTRL_DIAG0 && req.be == 4'hf ##1
        !req.wr ##1
        req.rd && req.addr == GDP_OFS_CTRL_DIAG0 && !req.wr |=>
            rdata == $past(req.wdata, 3))
        else $error("diagnostic readback wrong");

    reset_defaults_a: assert property (
        @(posedge clk_sys)
        $rose(rst_n) |-> dir_q == GDP_DIR_RESET
            && level_q == GDP_LEVEL_RESET
            && diag_q == GDP_CTRL_DIAG0_RESET && rdata == 32'h0000_0000)
        else $error("reset defaults not restored");

    dir_keep_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !lane_hit(req, GDP_OFS_PIN_DIRECTION) |=> $stable(dir_q))
        else $error("direction changed without write");

    level_keep_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !lane_hit(req, GDP_OFS_PIN_LEVEL) |=> $stable(level_q))
        else $error("data changed without write");

    sec_store_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        serial_bus_enable && lane_hit(req, GDP_OFS_PIN_LEVEL) |=>
            level_q[GDP_SCL_PIN] == $past(level_q[GDP_SCL_PIN])
            && level_q[GDP_SDA_PIN] == $past(level_q[GDP_SDA_PIN]))
        else $error("serial pin data bit written");

    out_read_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        read_hit(req, GDP_OFS_PIN_LEVEL) |=>
            ((rdata[7:0] ^ $past(level_q)) & $past(gpio_out_en)) == 8'h00)
        else $error("output level not read back");

    level_rsvd_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        read_hit(req, GDP_OFS_PIN_LEVEL) |=>
            rdata[31:16] == 16'h0000 && rdata[15:8] == GDP_RSVD_BYTE)
        else $error("data upper byte not zero");

    diag_read_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        read_hit(req, GDP_OFS_CTRL_DIAG0) |=> rdata == $past(diag_q))
        else $error("diagnostic read wrong");

    diag_lane_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        req.wr && req.addr == GDP_OFS_CTRL_DIAG0 |=>
            ((diag_q ^ $past(req.wdata)) & lane_mask($past(req.be)))
            == 32'h0000_0000)
        else $error("diagnostic lane not written");

    diag_keep_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !(req.wr && req.addr == GDP_OFS_CTRL_DIAG0) |=> $stable(diag_q))
        else $error("diagnostic changed without write");

    drive_value_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ((pin_out ^ level_q) & dir_q & ~sec_mask) == 8'h00)
        else $error("driven level differs from data");

    float_low_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (pin_out & ~pin_oe & ~sec_mask) == 8'h00)
        else $error("floating pin shows a level");

    dir_oe_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !serial_bus_enable |-> pin_oe == dir_q)
        else $error("direction not applied to drivers");

    serial_data_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        serial_bus_enable |-> pin_out[GDP_SCL_PIN] == serial.scl_out
            && pin_out[GDP_SDA_PIN] == serial.sda_out)
        else $error("serial outputs not handed over");

    serial_in_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        serial_scl_in == pin_in[GDP_SCL_PIN]
            && serial_sda_in == pin_in[GDP_SDA_PIN])
        else $error("serial inputs not passed through");

    serial_off_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !serial_bus_enable |-> pin_oe[GDP_SCL_PIN] == dir_q[GDP_SCL_PIN]
            && pin_oe[GDP_SDA_PIN] == dir_q[GDP_SDA_PIN])
        else $error("shared pins ignore direction");

endmodule

/* dv/gdp_port_bench.sv */
`timescale 1ns/1ps
module gdp_port_bench;
    import gdp_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic link_reset_n = 1'b1;
    logic global_reset_n = 1'b1;
    gdp_req_s req = '0;
    logic [31:0] rdata;
    logic serial_bus_enable = 1'b0;
    gdp_serial_s serial = '0;
    logic serial_scl_in;
    logic serial_sda_in;
    logic [7:0] pin_in = 8'ha5;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 clk_sys = ~clk_sys;

    gdp_port i_dut (.clk_sys(clk_sys), .resetn(resetn),
        .link_reset_n(link_reset_n), .global_reset_n(global_reset_n),
        .req(req), .rdata(rdata), .serial_bus_enable(serial_bus_enable),
        .serial(serial), .serial_scl_in(serial_scl_in),
        .serial_sda_in(serial_sda_in), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe));

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task automatic conclude;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Whole run needs about 80 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            conclude();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // ----------------------------------------
    // Register access
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d);
        @(posedge clk_sys);
        #1 req = '{1'b1, 1'b0, a, be, d};
        @(posedge clk_sys);
        #1 req = '0;
    endtask

    task automatic rd(input string name, input logic [7:0] a,
                      input logic [31:0] exp);
        @(posedge clk_sys);
        #1 req = '{1'b0, 1'b1, a, 4'hf, 32'h0000_0000};
        @(posedge clk_sys);
        #1 req = '0;
        chk(name, exp, rdata);
    endtask

    task automatic pins(input logic [7:0] oe, input logic [7:0] mask,
                        input logic [7:0] out);
        chk("pin_oe", {24'h000000, oe}, {24'h000000, pin_oe});
        chk("pin_out", {24'h000000, out}, {24'h000000, pin_out & mask});
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        #1 resetn = 1'b1;
        rd("dir", 8'hb4, 32'h0000_0000);
        rd("level", 8'hb6, 32'h0000_00a5);
        rd("diag", 8'hc0, 32'h0000_0000);
        pins(8'h00, 8'h00, 8'h00);
        $display("test reset_values done");
        wr(8'hb4, 4'hf, 32'h0000_ffff);
        rd("dir", 8'hb4, 32'h0000_00ff);
        wr(8'hb6, 4'hf, 32'h0000_ff3c);
        rd("level", 8'hb6, 32'h0000_003c);
        pins(8'hff, 8'hff, 8'h3c);
        wr(8'hb4, 4'h0, 32'h0000_0000);
        rd("dir", 8'hb4, 32'h0000_00ff);
        $display("test outputs done");
        serial_bus_enable = 1'b1;
        serial = '{1'b1, 1'b0, 1'b0, 1'b1};
        #1 pins(8'hdf, 8'hdf, 8'h0c);
        chk("serial_in", 32'h2, {30'h0, serial_sda_in, serial_scl_in});
        wr(8'hb6, 4'hf, 32'h0000_0000);
        pins(8'hdf, 8'hcf, 8'h00);
        serial_bus_enable = 1'b0;
        #1 pins(8'hff, 8'hff, 8'h30);
        $display("test serial done");
        wr(8'hb4, 4'hf, 32'h0000_000f);
        wr(8'hb6, 4'hf, 32'h0000_00ff);
        pin_in = 8'h00;
        rd("level", 8'hb6, 32'h0000_000f);
        pins(8'h0f, 8'h0f, 8'h0f);
        wr(8'hb4, 4'hf, 32'h0000_00ff);
        pins(8'hff, 8'hff, 8'h3f);
        $display("test input_discard done");
        wr(8'hc0, 4'hf, 32'h1234_5678);
        rd("diag", 8'hc0, 32'h1234_5678);
        rd("unmapped", 8'hb8, 32'h0000_0000);
        $display("test diag done");
        for (int k = 0; k < 2; k++) begin
            wr(8'hb4, 4'hf, 32'h0000_000f);
            wr(8'hb6, 4'hf, 32'h0000_000f);
            wr(8'hc0, 4'hf, 32'h0000_00ff);
            @(posedge clk_sys);
            #1 link_reset_n = (k != 0);
            global_reset_n = (k == 0);
            @(posedge clk_sys);
            #1 link_reset_n = 1'b1;
            global_reset_n = 1'b1;
            rd("dir", 8'hb4, 32'h0000_0000);
            rd("diag", 8'hc0, 32'h0000_0000);
            pins(8'h00, 8'h00, 8'h00);
            wr(8'hb4, 4'hf, 32'h0000_00ff);
            pins(8'hff, 8'hff, 8'h00);
        end
        $display("test resets done");
        conclude();
    end
endmodule
